// >>> pkg/ccu_map.svh
// Register offsets, opcode patterns, flag positions and reset values of the compare unit.
`ifndef CCU_MAP_SVH
`define CCU_MAP_SVH

// Avalon byte offsets, GPR window tag and register reset values.
`define REG_FLAGS        8'h00
`define REG_STATUS       8'h04
`define REG_CTRL         8'h08
`define REG_GPR_HI       2'h1
`define FLAGS_RESET      8'h00
`define CTRL_RESET       1'h1

// Status word bit positions.
`define STAT_BUSY        0
`define STAT_EXT         1
`define STAT_ILLEGAL     2

// Flag byte bit positions.
`define FLAG_C           7
`define FLAG_Z           6
`define FLAG_S           5
`define FLAG_V           4
`define FLAG_B           3

// Instruction word patterns.
`define OPC_EXTEND       16'h0007
`define OPC_COMPLEMENT   12'h454
`define OPC_REG_SHORT    4'h9
`define OPC_REG_REG      8'ha5
`define OPC_REG_FULL     12'haad
`define OPC_REG_HALF     12'haa5
`define OPC_INDEXED      8'h7d
`define OPC_ABS          8'h75
`define OPC_IND_HALF     12'had5
`define OPC_IND_WORD     12'hab5
`define OPC_IND_FULL     12'habd
`define OPC_IND_BYTE     12'had9
`define IND_BYTE_TAG     3'h5

// Operand selector codes shared by indexed and absolute forms.
`define SEL_UB           3'h0
`define SEL_SB           3'h1
`define SEL_UW           3'h2
`define SEL_SW           3'h3
`define SEL_RM_LONG      3'h4
`define SEL_MR_BYTE      3'h5
`define SEL_MR_WORD      3'h6
`define SEL_MR_LONG      3'h7

`endif

// >>> pkg/ccu_pkg.sv
// Types and the shared selector decode of the compare unit.
`include "ccu_map.svh"
package ccu_pkg;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} size_t;
  typedef enum logic [2:0] {FORM_COMPL, FORM_RR, FORM_RI, FORM_RM, FORM_MR, FORM_MI} form_t;
  typedef enum logic [2:0] {AM_NONE, AM_SHORT, AM_LONG, AM_IND, AM_IDX} amode_t;
  typedef enum logic [2:0] {IMM_NONE, IMM_SHORT8, IMM_HALF_U, IMM_HALF_S, IMM_FULL,
                            IMM_BYTE} imm_t;
  typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_WORD1 = 3'h1, ST_WORD2 = 3'h3,
                            ST_MREQ = 3'h2, ST_MWAIT = 3'h6, ST_EXEC = 3'h4} state_t;

  typedef struct packed {
    form_t form;
    size_t size;
    logic  sgn;
  } access_t;

  typedef struct packed {
    logic       legal;
    access_t    acc;
    logic [1:0] nwords;
    amode_t     amode;
    imm_t       immk;
    logic [3:0] dst;
    logic [3:0] src;
  } decode_t;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    size_t       size;
    logic        complement;
    logic        with_carry;
  } alu_in_t;

  // Maps a 3-bit operand selector onto direction, size and extension.
  function automatic access_t sel_access(input logic [2:0] sel);
    access_t r;
    r = '{form: FORM_RM, size: SZ_LONG, sgn: 1'b0};
    unique case (sel)
      `SEL_UB:      r = '{form: FORM_RM, size: SZ_BYTE, sgn: 1'b0};
      `SEL_SB:      r = '{form: FORM_RM, size: SZ_BYTE, sgn: 1'b1};
      `SEL_UW:      r = '{form: FORM_RM, size: SZ_WORD, sgn: 1'b0};
      `SEL_SW:      r = '{form: FORM_RM, size: SZ_WORD, sgn: 1'b1};
      `SEL_RM_LONG: r = '{form: FORM_RM, size: SZ_LONG, sgn: 1'b0};
      `SEL_MR_BYTE: r = '{form: FORM_MR, size: SZ_BYTE, sgn: 1'b0};
      `SEL_MR_WORD: r = '{form: FORM_MR, size: SZ_WORD, sgn: 1'b0};
      `SEL_MR_LONG: r = '{form: FORM_MR, size: SZ_LONG, sgn: 1'b0};
    endcase
    return r;
  endfunction
endpackage

// >>> hdl/ccu_decoder.sv
// First-word instruction decoder of the compare unit.
`timescale 1ns/1ps
module ccu_decoder import ccu_pkg::*; (
  input  wire logic [15:0] word0,
  output decode_t          dec
);
  // Patterns do not overlap, so the chain order only sets readability.
  always_comb begin
    dec        = '0;
    dec.acc    = '{form: FORM_RR, size: SZ_LONG, sgn: 1'b0};
    dec.amode  = AM_NONE;
    dec.immk   = IMM_NONE;
    dec.dst    = word0[3:0];
    dec.src    = word0[3:0];
    if (word0[15:4] == `OPC_COMPLEMENT) begin
      dec.legal    = 1'b1;
      dec.acc.form = FORM_COMPL;
    end else if (word0[15:12] == `OPC_REG_SHORT) begin
      dec.legal    = 1'b1;
      dec.acc.form = FORM_RI;
      dec.immk     = IMM_SHORT8;
      dec.dst      = word0[11:8];
    end else if (word0[15:8] == `OPC_REG_REG) begin
      dec.legal = 1'b1;
      dec.src   = word0[7:4];
    end else if (word0[15:4] == `OPC_REG_FULL || word0[15:4] == `OPC_REG_HALF) begin
      dec.legal    = 1'b1;
      dec.acc.form = FORM_RI;
      dec.immk     = word0[7] ? IMM_FULL : IMM_HALF_U;
      dec.nwords   = word0[7] ? 2'h2 : 2'h1;
    end else if (word0[15:8] == `OPC_INDEXED) begin
      // Direction and size come from the second word.
      dec.legal  = 1'b1;
      dec.acc    = sel_access(`SEL_RM_LONG);
      dec.amode  = AM_IDX;
      dec.nwords = 2'h1;
      dec.src    = word0[7:4];
    end else if (word0[15:8] == `OPC_ABS) begin
      dec.legal  = 1'b1;
      dec.acc    = sel_access(word0[6:4]);
      dec.amode  = word0[7] ? AM_LONG : AM_SHORT;
      dec.nwords = word0[7] ? 2'h2 : 2'h1;
    end else if (word0[15:4] == `OPC_IND_HALF || word0[15:4] == `OPC_IND_WORD ||
                 word0[15:4] == `OPC_IND_FULL || word0[15:4] == `OPC_IND_BYTE) begin
      dec.legal    = 1'b1;
      dec.acc.form = FORM_MI;
      dec.amode    = AM_IND;
      dec.nwords   = (word0[15:4] == `OPC_IND_FULL) ? 2'h2 : 2'h1;
      unique case (word0[15:4])
        `OPC_IND_HALF: dec.immk = IMM_HALF_S;
        `OPC_IND_WORD: begin
          dec.immk     = IMM_HALF_U;
          dec.acc.size = SZ_WORD;
        end
        `OPC_IND_FULL: dec.immk = IMM_FULL;
        default: begin
          dec.immk     = IMM_BYTE;
          dec.acc.size = SZ_BYTE;
        end
      endcase
    end
  end
endmodule

// >>> hdl/ccu_flag_calc.sv
// Subtractor and flag generator for complement, compare and compare with carry.
`timescale 1ns/1ps
module ccu_flag_calc import ccu_pkg::*; (
  input  alu_in_t          op,
  input  wire logic [7:0]  flags_in,
  output logic      [7:0]  flags_out
);
  logic [31:0] mask;
  logic [31:0] am;
  logic [31:0] bm;
  logic [32:0] diff;
  logic [31:0] res;
  logic [31:0] inv;
  logic        cin;
  logic        borrow;

  function automatic logic msb_of(input logic [31:0] v, input size_t sz);
    unique case (sz)
      SZ_BYTE: return v[7];
      SZ_WORD: return v[15];
      default: return v[31];
    endcase
  endfunction

  // Operands are masked to the access width, so bit width of diff is the borrow.
  always_comb begin
    unique case (op.size)
      SZ_BYTE: mask = 32'h0000_00ff;
      SZ_WORD: mask = 32'h0000_ffff;
      default: mask = 32'hffff_ffff;
    endcase
    am     = op.a & mask;
    bm     = op.b & mask;
    cin    = op.with_carry & flags_in[`FLAG_C];
    diff   = {1'b0, am} - {1'b0, bm} - {32'h0000_0000, cin};
    res    = diff[31:0] & mask;
    inv    = ~op.a;
    unique case (op.size)
      SZ_BYTE: borrow = diff[8];
      SZ_WORD: borrow = diff[16];
      default: borrow = diff[32];
    endcase
    // Interrupt enables and the spare bit pass through untouched.
    flags_out = flags_in; // [RULE22]
    if (op.complement) begin
      flags_out[`FLAG_C] = 1'b0; // [RULE2]
      flags_out[`FLAG_V] = 1'b0; // [RULE2]
      flags_out[`FLAG_Z] = (inv == 32'h0000_0000); // [RULE3]
      flags_out[`FLAG_S] = inv[31]; // [RULE3]
      flags_out[`FLAG_B] = (op.a == 32'h0000_0000); // [RULE2]
    end else begin
      flags_out[`FLAG_C] = borrow; // [RULE5] [RULE9]
      flags_out[`FLAG_S] = msb_of(res, op.size); // [RULE5] [RULE8]
      flags_out[`FLAG_V] = (msb_of(am, op.size) != msb_of(bm, op.size)) &&
                           (msb_of(res, op.size) != msb_of(am, op.size)); // [RULE5]
      flags_out[`FLAG_Z] = op.with_carry ? (flags_in[`FLAG_Z] && res == 32'h0000_0000)
                                         : (res == 32'h0000_0000); // [RULE6] [RULE10]
      flags_out[`FLAG_B] = (am == 32'h0000_0000) || (bm == 32'h0000_0000); // [RULE7]
    end
  end
endmodule

// >>> hdl/compare_complement_unit.sv
// Execution unit for complement, compare and compare with carry, with an Avalon register port.
//
// Behaviour
// RULE1 - Complement inverts every destination register bit; word is 454 hex plus register.
// RULE2 - Complement clears carry and overflow; blank set only if destination was zero.
// RULE3 - Complement zero and sign flags look at the full 32-bit result.
// RULE4 - Compare subtracts source from destination for flags only, writing nothing back.
// RULE5 - Compares set carry on borrow, sign from msb, overflow on signed overflow.
// RULE6 - Plain compare sets zero exactly when the difference is zero.
// RULE7 - Compares set blank when the destination or source value is zero.
// RULE8 - Compare flags use memory destination size, or 32 bits for registers.
// RULE9 - Compare with carry also subtracts the carry flag; operands stay unchanged.
// RULE10 - Compare with carry keeps zero only if it was set and result is zero.
// RULE11 - Prefix word 0007 hex turns the following compare into compare with carry.
// RULE12 - Register compare is A5 hex, source nibble, destination nibble.
// RULE13 - Short immediate compare is 9 hex, destination nibble, signed byte immediate.
// RULE14 - AAD hex takes a two-word immediate high first; AA5 hex one unsigned half.
// RULE15 - Indexed compare is 7D hex; second word holds selector and signed offset.
// RULE16 - 754 and 75C hex compare register with 32-bit memory; long address high first.
// RULE17 - 750 to 753 and 758 to 75B hex compare registers with narrow memory.
// RULE18 - 757/75F, 756/75E and 755/75D hex compare memory with a register.
// RULE19 - AD5, AB5 and ABD hex compare indirect memory with an immediate.
// RULE20 - AD9 hex compares an indirect byte; its second word must match x101.
// RULE21 - Flag byte: C7 Z6 S5 V4 B3, chained enable bit 1, master enable bit 0.
// RULE22 - These operations never change either interrupt enable bit.
// RULE23 - Narrow memory sources are sign or zero extended to 32 bits first.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module compare_complement_unit import ccu_pkg::*; (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  output logic             instr_ready,
  output logic             mem_rd_req,
  output logic      [31:0] mem_rd_addr,
  output size_t            mem_rd_size,
  input  wire logic        mem_rd_valid,
  input  wire logic [31:0] mem_rd_data,
  output logic      [7:0]  flags,
  output logic             exec_done
);
  logic [31:0] gpr_reg [0:15];
  state_t      state_reg;
  state_t      state_next;
  decode_t     dec_now;
  decode_t     dec_reg;
  logic [15:0] w0_reg;
  logic [15:0] w1_reg;
  logic [15:0] w2_reg;
  logic [31:0] mem_data_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  flags_next;
  logic        ext_reg;
  logic        enable_reg;
  logic        illegal_reg;
  logic        illegal_evt;
  logic        waitreq_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic        ready_reg;
  logic        req_reg;
  logic [31:0] addr_reg;
  size_t       size_reg;
  logic        done_reg;
  logic        take;
  logic        bus_wr;
  logic        wr_flags;
  logic        wr_status;
  logic        wr_ctrl;
  logic        wr_gpr;
  logic [3:0]  base_idx;
  logic [31:0] addr_calc;
  alu_in_t     alu_in;

  // Extends or trims a memory value of the given size to 32 bits.
  function automatic logic [31:0] ext_data(input logic [31:0] d, input size_t sz,
                                           input logic sgn);
    unique case (sz)
      SZ_BYTE: return {{24{sgn & d[7]}}, d[7:0]};
      SZ_WORD: return {{16{sgn & d[15]}}, d[15:0]};
      default: return d;
    endcase
  endfunction

  // Applies Avalon byte enables to a stored word.
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Builds the immediate source from the captured instruction words.
  function automatic logic [31:0] imm_value(input imm_t k, input logic [15:0] a,
                                            input logic [15:0] b, input logic [15:0] c);
    unique case (k)
      IMM_SHORT8: return {{24{a[7]}}, a[7:0]}; // [RULE13]
      IMM_HALF_U: return {16'h0000, b}; // [RULE14] [RULE19]
      IMM_HALF_S: return {{16{b[15]}}, b}; // [RULE19]
      IMM_FULL:   return {b, c}; // [RULE14] [RULE19]
      IMM_BYTE:   return {24'h00_0000, b[7:0]}; // [RULE20]
      default:    return 32'h0000_0000;
    endcase
  endfunction

  ccu_decoder u_decoder (
    .word0 (instr_word),
    .dec   (dec_now)
  );

  ccu_flag_calc u_flags (
    .op        (alu_in),
    .flags_in  (flags_reg),
    .flags_out (flags_next)
  );

  // Bus writes are granted only while idle with no word being taken, so they never
  // collide with an execute-stage write of the flags or a register.
  assign take      = instr_valid && ready_reg;
  assign bus_wr    = avs_write && !waitreq_reg;
  assign wr_flags  = bus_wr && avs_address == `REG_FLAGS;
  assign wr_status = bus_wr && avs_address == `REG_STATUS;
  assign wr_ctrl   = bus_wr && avs_address == `REG_CTRL;
  assign wr_gpr    = bus_wr && avs_address[7:6] == `REG_GPR_HI && avs_address[1:0] == 2'h0;

  // Indexed memory-destination forms use the destination nibble as base.
  assign base_idx  = (dec_reg.acc.form == FORM_MR) ? dec_reg.dst : dec_reg.src;

  // Effective address of the memory operand.
  always_comb begin
    unique case (dec_reg.amode)
      AM_SHORT: addr_calc = {{16{w1_reg[15]}}, w1_reg}; // [RULE16]
      AM_LONG:  addr_calc = {w1_reg, w2_reg}; // [RULE16]
      AM_IND:   addr_calc = gpr_reg[dec_reg.dst]; // [RULE19]
      AM_IDX:   addr_calc = gpr_reg[base_idx] + {{19{w1_reg[12]}}, w1_reg[12:0]}; // [RULE15]
      default:  addr_calc = 32'h0000_0000;
    endcase
  end

  // Operand selection; register destinations are always judged at 32 bits.
  always_comb begin
    alu_in.a          = gpr_reg[dec_reg.dst];
    alu_in.b          = imm_value(dec_reg.immk, w0_reg, w1_reg, w2_reg);
    alu_in.size       = SZ_LONG; // [RULE8]
    alu_in.complement = 1'b0;
    alu_in.with_carry = ext_reg; // [RULE9] [RULE11]
    unique case (dec_reg.acc.form)
      FORM_COMPL: alu_in.complement = 1'b1;
      FORM_RR:    alu_in.b = gpr_reg[dec_reg.src]; // [RULE12]
      FORM_RI:    alu_in.b = imm_value(dec_reg.immk, w0_reg, w1_reg, w2_reg);
      FORM_RM:    alu_in.b = ext_data(mem_data_reg, dec_reg.acc.size, dec_reg.acc.sgn); // [RULE23]
      FORM_MR: begin
        alu_in.a    = mem_data_reg;
        alu_in.b    = gpr_reg[dec_reg.src]; // [RULE18]
        alu_in.size = dec_reg.acc.size; // [RULE8]
      end
      FORM_MI: begin
        alu_in.a    = mem_data_reg;
        alu_in.size = dec_reg.acc.size; // [RULE8]
      end
      default:    alu_in.complement = 1'b0;
    endcase
  end

  // Sequencer: collect trailing words, fetch the memory operand, then execute.
  always_comb begin
    state_next  = state_reg;
    illegal_evt = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (take && instr_word == `OPC_EXTEND) begin
          illegal_evt = ext_reg;
        end else if (take) begin
          if (!dec_now.legal || (ext_reg && dec_now.acc.form == FORM_COMPL)) begin
            illegal_evt = 1'b1;
          end else if (dec_now.nwords == 2'h0) begin
            state_next = ST_EXEC;
          end else begin
            state_next = ST_WORD1;
          end
        end
      end
      ST_WORD1: begin
        if (take) begin
          if (dec_reg.immk == IMM_BYTE && instr_word[10:8] != `IND_BYTE_TAG) begin
            illegal_evt = 1'b1; // [RULE20]
            state_next  = ST_IDLE;
          end else if (dec_reg.nwords == 2'h2) begin
            state_next = ST_WORD2;
          end else if (dec_reg.amode != AM_NONE) begin
            state_next = ST_MREQ;
          end else begin
            state_next = ST_EXEC;
          end
        end
      end
      ST_WORD2: begin
        if (take) begin
          state_next = (dec_reg.amode != AM_NONE) ? ST_MREQ : ST_EXEC;
        end
      end
      ST_MREQ:  state_next = ST_MWAIT;
      ST_MWAIT: begin
        if (mem_rd_valid) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // State register and the word-accept strobe toward fetch.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= enable_reg && (state_next == ST_IDLE || state_next == ST_WORD1 ||
                                  state_next == ST_WORD2);
    end
  end

  // Instruction word capture; the prefix is held until its instruction retires.
  always_ff @(posedge clk) begin
    if (srst) begin
      w0_reg  <= 16'h0000;
      w1_reg  <= 16'h0000;
      w2_reg  <= 16'h0000;
      ext_reg <= 1'b0;
      dec_reg <= '0;
    end else begin
      if (take && state_reg == ST_IDLE) begin
        if (instr_word == `OPC_EXTEND) begin
          ext_reg <= 1'b1; // [RULE11]
        end else begin
          w0_reg  <= instr_word;
          dec_reg <= dec_now; // [RULE1] [RULE12] [RULE13] [RULE14] [RULE16] [RULE17] [RULE18]
        end
      end
      if (take && state_reg == ST_WORD1) begin
        w1_reg <= instr_word;
        if (dec_reg.amode == AM_IDX) begin
          dec_reg.acc <= sel_access(instr_word[15:13]); // [RULE15]
        end
      end
      if (take && state_reg == ST_WORD2) begin
        w2_reg <= instr_word;
      end
      if (state_reg == ST_EXEC || (illegal_evt && instr_word != `OPC_EXTEND)) begin
        ext_reg <= 1'b0;
      end
    end
  end

  // Memory read request; the unit only ever reads operands.
  always_ff @(posedge clk) begin
    if (srst) begin
      req_reg      <= 1'b0;
      addr_reg     <= 32'h0000_0000;
      size_reg     <= SZ_LONG;
      mem_data_reg <= 32'h0000_0000;
    end else if (state_reg == ST_MREQ) begin
      req_reg  <= 1'b1;
      addr_reg <= addr_calc;
      size_reg <= dec_reg.acc.size;
    end else if (state_reg == ST_MWAIT && mem_rd_valid) begin
      req_reg      <= 1'b0;
      mem_data_reg <= ext_data(mem_rd_data, size_reg, 1'b0);
    end
  end

  // Flag register: software writes while idle, execution updates the C, Z, S, V and B bits.
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_reg <= `FLAGS_RESET;
    end else if (wr_flags && avs_byteenable[0]) begin
      flags_reg <= {avs_writedata[7:3], 1'b0, avs_writedata[1:0]}; // [RULE21]
    end else if (state_reg == ST_EXEC) begin
      flags_reg <= flags_next; // [RULE5] [RULE22]
    end
  end

  // Register file; only the complement writes back, compares leave it alone.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) begin
        gpr_reg[i] <= 32'h0000_0000;
      end
    end else if (wr_gpr) begin
      gpr_reg[avs_address[5:2]] <= merge_be(gpr_reg[avs_address[5:2]], avs_writedata,
                                            avs_byteenable);
    end else if (state_reg == ST_EXEC && dec_reg.acc.form == FORM_COMPL) begin
      gpr_reg[dec_reg.dst] <= ~gpr_reg[dec_reg.dst]; // [RULE1] [RULE4]
    end
  end

  // Control enable and the sticky illegal-word flag; a new event beats the clear.
  always_ff @(posedge clk) begin
    if (srst) begin
      enable_reg  <= `CTRL_RESET;
      illegal_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      if (wr_ctrl && avs_byteenable[0]) begin
        enable_reg <= avs_writedata[0];
      end
      if (illegal_evt) begin
        illegal_reg <= 1'b1;
      end else if (wr_status && avs_byteenable[0] && avs_writedata[`STAT_ILLEGAL]) begin
        illegal_reg <= 1'b0;
      end
      done_reg <= (state_reg == ST_EXEC);
    end
  end

  // Read multiplexer; unmapped or unaligned offsets read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == `REG_FLAGS) begin
      rd_mux = {24'h00_0000, flags_reg};
    end else if (avs_address == `REG_STATUS) begin
      rd_mux[`STAT_BUSY]    = (state_reg != ST_IDLE);
      rd_mux[`STAT_EXT]     = ext_reg;
      rd_mux[`STAT_ILLEGAL] = illegal_reg;
    end else if (avs_address == `REG_CTRL) begin
      rd_mux[0] = enable_reg;
    end else if (avs_address[7:6] == `REG_GPR_HI && avs_address[1:0] == 2'h0) begin
      rd_mux = gpr_reg[avs_address[5:2]];
    end
  end

  // Avalon slave: waitrequest drops for one cycle per access. Reads answer at once;
  // writes wait for an idle sequencer, which trades bus latency for no write clash.
  always_ff @(posedge clk) begin
    if (srst) begin
      waitreq_reg <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      waitreq_reg <= !(waitreq_reg && (avs_read || (avs_write && state_reg == ST_IDLE &&
                                                    !take)));
      if (avs_read && waitreq_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = waitreq_reg;
  assign instr_ready     = ready_reg;
  assign mem_rd_req      = req_reg;
  assign mem_rd_addr     = addr_reg;
  assign mem_rd_size     = size_reg;
  assign flags           = flags_reg;
  assign exec_done       = done_reg;
endmodule

// >>> dv/ccu_mem_model.sv
// Operand memory responder for the compare unit.
`timescale 1ns/1ps
module ccu_mem_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic        slow,
  output logic             valid = 1'b0,
  output logic      [31:0] data = 32'h0
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  cnt = 2'h0;
  // Answers after one or four cycles; idle data toggles so stale words never pass as valid.
  always @(posedge clk) begin
    valid <= 1'b0;
    data <= ~data;
    if (req && !valid) begin
      cnt <= cnt + 2'h1;
      if (cnt == {slow, slow}) begin
        valid <= 1'b1;
        data <= mem.exists(addr) ? mem[addr] : 32'h0;
        cnt <= 2'h0;
      end
    end
  end
endmodule

// >>> dv/ccu_monitor.sv
// Port checker for the compare unit.
`timescale 1ns/1ps
module ccu_monitor (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        avs_waitrequest,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        instr_ready,
  input wire logic        mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic        mem_rd_valid,
  input wire logic [7:0]  flags,
  input wire logic        exec_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // A complement word taken and retired two edges later.
  sequence s_com;
    instr_valid && instr_ready && instr_word[15:4] == 12'h454 ##2 exec_done;
  endsequence
  a_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_req_hold: assert property (mem_rd_req && !mem_rd_valid |=>
    mem_rd_req && $stable(mem_rd_addr)) else $error("read request moved");
  a_req_drop: assert property (mem_rd_req && mem_rd_valid |=> !mem_rd_req)
    else $error("read request kept");
  a_done_pulse: assert property (exec_done |=> !exec_done) else $error("done too long");
  a_bit_two: assert property (flags[2] == 1'b0) else $error("flag bit 2 set");
  a_int_kept: assert property (exec_done |-> $stable(flags[1:0]))
    else $error("enable bits changed");
  a_com_cv: assert property (s_com |-> !flags[7] && !flags[4])
    else $error("complement left carry or overflow");
  a_reset_clear: assert property ($fell(srst) |-> flags == 8'h00 && !mem_rd_req)
    else $error("reset state wrong");
endmodule
bind compare_complement_unit ccu_monitor mon (.clk(clk), .srst(srst),
  .avs_waitrequest(avs_waitrequest), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready(instr_ready), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
  .mem_rd_valid(mem_rd_valid), .flags(flags), .exec_done(exec_done));

// >>> dv/tb.sv
// Self-checking bench for the compare unit.
`timescale 1ns/1ps
module tb;
  typedef logic [15:0] prog_t [4];
  logic        clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, slow = 1'b0;
  logic [7:0]  avs_address = 8'h00, flags;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, mem_rd_addr, mem_rd_data;
  logic [15:0] instr_word = 16'h0;
  logic        instr_valid = 1'b0, avs_waitrequest, instr_ready, mem_rd_req, mem_rd_valid;
  logic        exec_done;
  int          miscompares = 0, n_compared = 0;
  always #25 clk = ~clk;
  compare_complement_unit uut (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_size(),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .flags(flags),
    .exec_done(exec_done));
  ccu_mem_model mem_i (.clk(clk), .req(mem_rd_req), .addr(mem_rd_addr), .slow(slow),
    .valid(mem_rd_valid), .data(mem_rd_data));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon access; a read checks its data against d.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    if (!w) chk(avs_readdata, d);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  // Loads flags, feeds n words and checks the flag byte at retire.
  task automatic op(input logic [7:0] f, input int n, input prog_t w, input logic [7:0] e);
    bus(1'b1, 8'h00, {24'h0, f});
    for (int i = 0; i < n; i++) begin
      instr_valid <= 1'b1;
      instr_word <= w[i];
      do @(posedge clk); while (instr_ready !== 1'b1);
    end
    instr_valid <= 1'b0;
    do @(posedge clk); while (exec_done !== 1'b1);
    chk({24'h0, flags}, {24'h0, e});
    @(posedge clk);
  endtask
  task automatic t_com();
    bus(1'b1, 8'h5c, 32'h7f37_b2d3);
    op(8'hd3, 1, '{16'h4547, 0, 0, 0}, 8'h23);
    bus(1'b0, 8'h5c, 32'h80c8_4d2c);
    bus(1'b1, 8'h44, 32'h0000_ffff);
    op(8'h40, 1, '{16'h4541, 0, 0, 0}, 8'h20);
    op(8'h00, 1, '{16'h4540, 0, 0, 0}, 8'h28);
  endtask
  task automatic t_reg();
    bus(1'b1, 8'h4c, 32'h16);
    bus(1'b1, 8'h6c, 32'h20);
    op(8'h03, 1, '{16'ha5b3, 0, 0, 0}, 8'ha3);
    bus(1'b0, 8'h4c, 32'h16);
    op(8'h00, 1, '{16'ha523, 0, 0, 0}, 8'h08);
    bus(1'b1, 8'h6c, 32'h16);
    op(8'h40, 2, '{16'h0007, 16'ha5b3, 0, 0}, 8'h40);
    op(8'h00, 2, '{16'h0007, 16'ha5b3, 0, 0}, 8'h00);
    op(8'h80, 2, '{16'h0007, 16'ha5b3, 0, 0}, 8'ha0);
    op(8'h00, 1, '{16'h93ff, 0, 0, 0}, 8'h80);
    op(8'h00, 3, '{16'haad3, 16'h0000, 16'h0016, 0}, 8'h40);
    op(8'h00, 2, '{16'haa53, 16'h8000, 0, 0}, 8'ha0);
    op(8'h00, 3, '{16'haad3, 16'h8000, 16'h0000, 0}, 8'hb0);
  endtask
  task automatic t_mem();
    mem_i.mem[32'hffff_b034] = 32'hab00_002e;
    mem_i.mem[32'hffff_b020] = 32'h5a00_0091;
    bus(1'b1, 8'h70, 32'h1b);
    op(8'h00, 2, '{16'h755c, 16'hb034, 0, 0}, 8'h00);
    slow <= 1'b1;
    bus(1'b1, 8'h68, 32'hffff_b020);
    bus(1'b1, 8'h70, 32'h16);
    op(8'h00, 2, '{16'h7dac, 16'h2000, 0, 0}, 8'h80);
    op(8'h00, 2, '{16'hab5a, 16'h0191, 0, 0}, 8'ha0);
    bus(1'b1, 8'h00, 32'hff);
    bus(1'b0, 8'h00, 32'hfb);
    bus(1'b0, 8'h0c, 32'h0);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_com();
    t_reg();
    t_mem();
    wrap_up();
  end
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule
